// >>> bench/dpw_i2c_master.sv
// Serial bus master model for the wiper slave
`timescale 1ns/10ps
module dpw_i2c_master #(
	parameter int Q = 2
) (
	// Pacing clock
	input	wire logic	clk_i,
	// Bus pins, SDA open drain with pull-up
	input	wire logic	sda_i,
	output	logic		scl_o,
	output	logic		pull_o
);
	// Bus idle at time zero
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	// Third of a bit time of Q clocks; a larger Q gives a slower master
	task automatic w();
		repeat (Q) @(posedge clk_i);
		#1;
	endtask : w
	// data moves only with SCL low
	task automatic bit_x(input logic b, output logic r);
		pull_o = !b;
		w();
		scl_o = 1'b1;
		w();
		r = sda_i;
		scl_o = 1'b0;
		w();
	endtask : bit_x
	task automatic start();
		pull_o = 1'b0;
		w();
		scl_o = 1'b1;
		w();
		pull_o = 1'b1;
		w();
		scl_o = 1'b0;
		w();
	endtask : start
	task automatic stop();
		pull_o = 1'b1;
		w();
		scl_o = 1'b1;
		w();
		pull_o = 1'b0;
		w();
	endtask : stop
	// eight bits MSB first, then the acknowledge clock
	task automatic xfer(input logic [7:0] d, input logic ak,
		output logic [7:0] r, output logic ar);
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(ak, ar);
	endtask : xfer
endmodule : dpw_i2c_master

// >>> bench/dpw_slave_asserts.sv
// Port assertions for the dual wiper command slave
`timescale 1ns/10ps
module dpw_slave_asserts #(
	parameter int TAPS = 256
) (
	// Clocks, reset, enable
	input	wire logic			mclk_i,
	input	wire logic			rst_i,
	input	wire logic			ce_i,
	input	wire logic			lclk_i,
	// Serial pins and address
	input	wire logic			scl_i,
	input	wire logic			sda_i,
	input	wire logic			sda_o,
	input	wire logic			sda_oe_o,
	input	wire logic [3:0]		address_select_pins_i,
	// Wiper positions and taps
	input	wire dpw_pkg::dpw_wipers_t	wiper_o,
	input	wire logic [1:0][TAPS-1:0]	tap_o
);
	// Taps follow the wiper one system cycle later, one switch only
	a_tap_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
		tap_o[0] == (TAPS'(1) << $past(wiper_o.zero)))
		else $error("tap zero does not match wiper");
	a_tap_one: assert property (@(posedge mclk_i) disable iff (rst_i)
		tap_o[1] == (TAPS'(1) << $past(wiper_o.one)))
		else $error("tap one does not match wiper");
	a_tap_onehot: assert property (@(posedge mclk_i) disable iff (rst_i)
		$onehot(tap_o[0]) && $onehot(tap_o[1]))
		else $error("tap outputs not one-hot");
	// Both wipers leave reset at midscale
	a_reset_mid: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(rst_i) |-> wiper_o == 16'h8080)
		else $error("wipers not at midscale after reset");
	// A command touches one pot, so both never move together
	a_one_pot: assert property (@(posedge mclk_i) disable iff (rst_i)
		!($changed(wiper_o.zero) && $changed(wiper_o.one)))
		else $error("both wipers changed at once");
	// The device moves SDA only while SCL is low
	a_oe_scl_low: assert property (@(posedge lclk_i) disable iff (rst_i)
		$changed(sda_oe_o) |-> !scl_i)
		else $error("SDA drive changed with SCL high");
	// A pulled bit stands for a good part of a bit time
	a_oe_stands: assert property (@(posedge lclk_i) disable iff (rst_i)
		$rose(sda_oe_o) |=> sda_oe_o [*8])
		else $error("SDA pull too short");
	// The bus is never held low past a byte
	a_oe_release: assert property (@(posedge lclk_i) disable iff (rst_i)
		$rose(sda_oe_o) |-> ##[1:600] !sda_oe_o)
		else $error("SDA not released");
	a_open_drain: assert property (@(posedge lclk_i) disable iff (rst_i)
		sda_o == 1'b0)
		else $error("SDA output not low");
endmodule : dpw_slave_asserts

// >>> bench/test_dual_pot_wiper_command_slave.sv
// Self-checking bench for the dual wiper command slave
`timescale 1ns/10ps
module test_dual_pot_wiper_command_slave;
	localparam logic [3:0] TYPE = 4'hA; // Arbitrary device type code
	localparam logic [7:0] ADR = {TYPE, 4'h3};
	logic mclk_i = 1'b0;
	logic lclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl, pull, sda, sda_oe, sda_out;
	dpw_pkg::dpw_wipers_t wip;
	logic [1:0][255:0] tap;
	int mismatches = 0;
	int compares = 0;

	// System clock, and a link clock unrelated in phase
	always #25 mclk_i = ~mclk_i;
	initial #1.7 forever #3 lclk_i = ~lclk_i;
	// Pull-up: the wire is low while anyone pulls
	assign sda = !(sda_oe | pull);

	dpw_slave #(.DEV_TYPE(TYPE)) DUT (
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .lclk_i(lclk_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
		.address_select_pins_i(4'h3), .wiper_o(wip), .tap_o(tap)
	);
	dpw_i2c_master master (.clk_i(mclk_i), .sda_i(sda), .scl_o(scl),
		.pull_o(pull));

	// Compare and count
	task automatic chk(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	// Wait out the crossing delay, then check wiper and tap
	task automatic see(input logic p, input logic [7:0] e);
		repeat (20) @(posedge mclk_i);
		#1;
		chk("wiper", e, p ? wip.one : wip.zero);
		chk("tap", 8'h1, {7'h0, tap[p] === (256'h1 << e)});
		chk("sda out", 8'h0, {7'h0, sda_out});
	endtask : see
	// Three byte write; ea holds expected SDA levels at each ack clock
	task automatic wr(input logic [7:0] a, i, d, input logic [2:0] ea);
		logic [7:0] r;
		logic [2:0] k;
		master.start();
		master.xfer(a, 1'b1, r, k[2]);
		master.xfer(i, 1'b1, r, k[1]);
		master.xfer(d, 1'b1, r, k[0]);
		master.stop();
		chk("acks", {5'h0, ea}, {5'h0, k});
	endtask : wr
	// Read once with ack, again with nack, then one more byte
	task automatic rd(input logic [7:0] i, e);
		logic [7:0] r [3];
		logic [2:0] k;
		master.start();
		master.xfer(ADR, 1'b1, r[0], k[2]);
		master.xfer(i, 1'b1, r[0], k[1]);
		master.xfer(8'hFF, 1'b0, r[0], k[0]);
		master.xfer(8'hFF, 1'b1, r[1], k[0]);
		master.xfer(8'hFF, 1'b1, r[2], k[0]);
		master.stop();
		chk("read acks", 8'h0, {6'h0, k[2:1]});
		chk("read", e, r[0]);
		chk("resend", e, r[1]);
		chk("idle", 8'hFF, r[2]);
	endtask : rd
	// Load v, step by s (bit set is up); the stop edge steps down
	task automatic st(input logic p, input logic [7:0] v, input logic [3:0] s);
		logic [7:0] r;
		logic k;
		wr(ADR, {7'h50, p}, v, 3'h0);
		master.start();
		master.xfer(ADR, 1'b1, r, k);
		master.xfer({7'h10, p}, 1'b1, r, k);
		chk("step ack", 8'h0, {7'h0, k});
		for (int j = 0; j < 4; j++) begin
			master.bit_x(s[j], k);
			chk("no ack", {7'h0, s[j]}, {7'h0, k});
			if (s[j] && v != 8'hFF)
				v++;
			else if (!s[j] && v != 8'h00)
				v--;
		end
		master.stop();
		if (v != 8'h00)
			v--;
		see(p, v);
	endtask : st
	// Counts and verdict
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		repeat (4) @(posedge mclk_i);
		#1 rst_i = 1'b0;
		see(1'b0, 8'h80);
		see(1'b1, 8'h80);
		$display("test reset done");
		wr(ADR, 8'hA1, 8'h3C, 3'h0);
		see(1'b1, 8'h3C);
		wr(ADR, 8'hA0, 8'hC3, 3'h0);
		see(1'b0, 8'hC3);
		see(1'b1, 8'h3C);
		$display("test write done");
		rd(8'h91, 8'h3C);
		rd(8'h90, 8'hC3);
		$display("test read done");
		wr({TYPE, 4'h6}, 8'hA0, 8'h11, 3'h7);
		wr({TYPE ^ 4'h1, 4'h3}, 8'hA0, 8'h11, 3'h7);
		wr(ADR, 8'hA2, 8'h11, 3'h3);
		wr(ADR, 8'hB0, 8'h11, 3'h3);
		see(1'b0, 8'hC3);
		$display("test refuse done");
		st(1'b0, 8'hFE, 4'b0111);
		st(1'b1, 8'h01, 4'b1100);
		$display("test step done");
		complete_run();
	end
	// Cut a hang short well past the expected run time
	initial begin
		#400000;
		mismatches++;
		complete_run();
	end
endmodule : test_dual_pot_wiper_command_slave

// Port checker on every slave instance
bind dpw_slave dpw_slave_asserts #(.TAPS(TAPS)) u_chk (
	.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .lclk_i(lclk_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.address_select_pins_i(address_select_pins_i),
	.wiper_o(wiper_o), .tap_o(tap_o)
);

// >>> verilog/_unused_marker_none.sv
// Holds no logic

// >>> verilog/dpw_cfg.svh
// Constants for the dual wiper command slave
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

// Instruction byte opcodes and the function field that must be zero
`define DPW_OP_READ        4'h9
`define DPW_OP_WRITE       4'hA
`define DPW_OP_STEP        4'h2
`define DPW_FUNC_NONE      3'h0

// Instruction byte field positions
`define DPW_OP_HI          7
`define DPW_OP_LO          4
`define DPW_FUNC_HI        3
`define DPW_FUNC_LO        1
`define DPW_SEL_BIT        0

// Slave address byte field positions
`define DPW_TYPE_HI        7
`define DPW_TYPE_LO        4
`define DPW_ADDR_HI        3
`define DPW_ADDR_LO        0

// Bits per byte before the acknowledge clock
`define DPW_BITS_PER_BYTE  4'h8
`define DPW_CNT_ZERO       4'h0
`define DPW_CNT_STEP       4'h1

// Wiper register values
`define DPW_WIPER_RESET    8'h80
`define DPW_WIPER_MAX      8'hFF
`define DPW_WIPER_MIN      8'h00
`define DPW_WIPER_STEP     8'h01

`endif

// >>> verilog/dpw_pkg.sv
// Types shared by the dual wiper command slave
package dpw_pkg;

	// Link side command states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_INSTR = 7'h04,
		ST_WDATA = 7'h08,
		ST_RDATA = 7'h10,
		ST_STEP  = 7'h20,
		ST_WAIT  = 7'h40
	} dpw_state_t;

	// Both wiper positions travelling together
	typedef struct packed {
		logic [7:0] one;
		logic [7:0] zero;
	} dpw_wipers_t;

endpackage : dpw_pkg

// >>> verilog/dpw_slave.sv
// Serial command slave holding two wiper position registers
`timescale 1ns/10ps
`include "dpw_cfg.svh"

// Summary of operation
// - Start is SDA falling with SCL high; stop is SDA rising with SCL high.
// - Address byte must carry the device type code and the select pins.
// - Receiver pulls SDA low on the ninth clock after eight bits.
// - Acknowledge a start followed by a matching slave address byte.
// - In a write transfer acknowledge every received byte; the code does not ack a refused instruction or bytes after the data byte.
// - Read shifts eight bits, releases SDA, then samples master acknowledge.
// - Missing master acknowledge stops sending; release SDA, wait for stop.
// - After the step command is acknowledged, no further acknowledges.
// - Instruction byte: opcode high nibble, three zero bits, pot select.
// - Opcode 1001 reads the selected wiper position register.
// - Opcode 1010 loads the next data byte into the selected wiper.
// - Opcode 0010 enables single steps of the selected wiper.
// - Pot select 0 picks potentiometer zero, 1 picks potentiometer one.
// - Commands are address byte, instruction byte, one data phase.
// - Step mode, SCL pulse with SDA high moves toward high terminal.
// - Step mode, SCL pulse with SDA low moves toward low terminal.
// - Two 8-bit wiper registers, each decoded to one of 256 taps.
// - Wiper registers are volatile and start at midscale.
module dpw_slave #(
	parameter logic [3:0] DEV_TYPE = 4'hA, // Arbitrary device type code
	parameter int         WIDTH    = 8,
	parameter int         TAPS     = 256
) (
	// System clock, reset, enable
	input  wire logic                    mclk_i,
	input  wire logic                    rst_i,
	input  wire logic                    ce_i,
	// Free running link sampling clock
	input  wire logic                    lclk_i,
	// Serial bus pins, SDA open drain
	input  wire logic                    scl_i,
	input  wire logic                    sda_i,
	output logic                         sda_o,
	output logic                         sda_oe_o,
	// Address select pins
	input  wire logic [3:0]              address_select_pins_i,
	// Wiper positions and tap switches
	output dpw_pkg::dpw_wipers_t         wiper_o,
	output logic      [1:0][TAPS-1:0]    tap_o
);

	// Reset and enable carried into the link domain
	logic                 lrst_m, lrst_s;
	logic                 lce_m, lce_s;

	// Pin synchronisers and edge history
	logic                 scl_m, scl_s, scl_p;
	logic                 sda_m, sda_s, sda_p;
	logic [3:0]           addr_m, addr_s;
	logic                 scl_rise, scl_fall;
	logic                 bus_start, bus_stop;

	// Command engine state
	dpw_pkg::dpw_state_t  st_q, st_d;
	dpw_pkg::dpw_state_t  nxt_q, nxt_d, nxt_ev;
	logic [3:0]           cnt_q, cnt_d;
	logic [7:0]           shr_q, shr_d;
	logic [7:0]           tx_q, tx_d;
	logic                 oe_q, oe_d;
	logic                 ack_q, ack_d;
	logic                 sel_q, sel_d;
	logic                 acc_ev;
	logic [WIDTH-1:0]     wip_q [0:1];
	logic [WIDTH-1:0]     wip_d [0:1];

	// Word crossing, link side
	dpw_pkg::dpw_wipers_t hold_q, hold_d;
	logic                 req_q, req_d;
	logic                 back_m, back_s;

	// Word crossing, system side
	logic                 req_m, req_s;
	logic                 back_q, back_d;
	dpw_pkg::dpw_wipers_t wiper_d;

	// Open drain: the pin is only ever pulled low
	assign sda_o    = 1'b0;
	assign sda_oe_o = oe_q;

	// Reset and enable synchronisers; never frozen so reset always lands
	always_ff @(posedge lclk_i) begin
		lrst_m <= rst_i;
		lrst_s <= lrst_m;
		lce_m  <= ce_i;
		lce_s  <= lce_m;
	end

	// Pin synchronisers, idle bus levels after reset
	always_ff @(posedge lclk_i) begin
		if (lrst_s) begin
			scl_m  <= 1'b1;
			scl_s  <= 1'b1;
			scl_p  <= 1'b1;
			sda_m  <= 1'b1;
			sda_s  <= 1'b1;
			sda_p  <= 1'b1;
			addr_m <= 4'h0;
			addr_s <= 4'h0;
		end else if (lce_s) begin
			scl_m  <= scl_i;
			scl_s  <= scl_m;
			scl_p  <= scl_s;
			sda_m  <= sda_i;
			sda_s  <= sda_m;
			sda_p  <= sda_s;
			addr_m <= address_select_pins_i;
			addr_s <= addr_m;
		end
	end

	// Bus events from the synchronised levels
	assign scl_rise  = scl_s & ~scl_p;
	assign scl_fall  = ~scl_s & scl_p;
	assign bus_start = scl_s & scl_p & sda_p & ~sda_s;
	assign bus_stop  = scl_s & scl_p & ~sda_p & sda_s;

	// Judge a complete byte: accept it and pick the following state
	always_comb begin
		acc_ev = 1'b0;
		nxt_ev = dpw_pkg::ST_WAIT;
		unique case (st_q)
			dpw_pkg::ST_ADDR: begin
				acc_ev = (shr_q[`DPW_TYPE_HI:`DPW_TYPE_LO] == DEV_TYPE) &&
					(shr_q[`DPW_ADDR_HI:`DPW_ADDR_LO] == addr_s);
				nxt_ev = dpw_pkg::ST_INSTR;
			end
			dpw_pkg::ST_INSTR: begin
				if (shr_q[`DPW_FUNC_HI:`DPW_FUNC_LO] == `DPW_FUNC_NONE) begin
					if (shr_q[`DPW_OP_HI:`DPW_OP_LO] == `DPW_OP_READ) begin
						acc_ev = 1'b1;
						nxt_ev = dpw_pkg::ST_RDATA;
					end else if (shr_q[`DPW_OP_HI:`DPW_OP_LO] ==
						`DPW_OP_WRITE) begin
						acc_ev = 1'b1;
						nxt_ev = dpw_pkg::ST_WDATA;
					end else if (shr_q[`DPW_OP_HI:`DPW_OP_LO] ==
						`DPW_OP_STEP) begin
						acc_ev = 1'b1;
						nxt_ev = dpw_pkg::ST_STEP;
					end
				end
			end
			dpw_pkg::ST_WDATA: begin
				// single data byte, then only a start or stop
				acc_ev = 1'b1;
				nxt_ev = dpw_pkg::ST_WAIT;
			end
			dpw_pkg::ST_IDLE, dpw_pkg::ST_RDATA, dpw_pkg::ST_STEP,
			dpw_pkg::ST_WAIT: begin
				acc_ev = 1'b0;
			end
		endcase
	end

	// Command engine next state
	always_comb begin
		st_d     = st_q;
		nxt_d    = nxt_q;
		cnt_d    = cnt_q;
		shr_d    = shr_q;
		tx_d     = tx_q;
		oe_d     = oe_q;
		ack_d    = ack_q;
		sel_d    = sel_q;
		wip_d[0] = wip_q[0];
		wip_d[1] = wip_q[1];
		// start or stop ends any command
		if (bus_start) begin
			st_d  = dpw_pkg::ST_ADDR;
			cnt_d = `DPW_CNT_ZERO;
			oe_d  = 1'b0;
			ack_d = 1'b0;
		end else if (bus_stop) begin
			st_d  = dpw_pkg::ST_IDLE;
			cnt_d = `DPW_CNT_ZERO;
			oe_d  = 1'b0;
			ack_d = 1'b0;
		end else begin
			unique case (st_q)
				dpw_pkg::ST_ADDR, dpw_pkg::ST_INSTR,
				dpw_pkg::ST_WDATA: begin
					if (scl_rise && cnt_q != `DPW_BITS_PER_BYTE) begin
						shr_d = {shr_q[6:0], sda_s};
						cnt_d = cnt_q + `DPW_CNT_STEP;
					end else if (scl_fall && ack_q) begin
						// Ninth clock over: release and move on
						oe_d  = 1'b0;
						ack_d = 1'b0;
						cnt_d = `DPW_CNT_ZERO;
						st_d  = nxt_q;
						// first read bit goes out on this fall
						if (nxt_q == dpw_pkg::ST_RDATA) begin
							oe_d = ~tx_q[7];
						end
					end else if (scl_fall &&
						cnt_q == `DPW_BITS_PER_BYTE) begin
						if (acc_ev) begin
							// pull low for the ninth clock
							oe_d  = 1'b1;
							ack_d = 1'b1;
							nxt_d = nxt_ev;
							if (st_q == dpw_pkg::ST_INSTR) begin
								sel_d = shr_q[`DPW_SEL_BIT];
								tx_d  = wip_q[shr_q[`DPW_SEL_BIT]];
							end
							if (st_q == dpw_pkg::ST_WDATA) begin
								wip_d[sel_q] = shr_q;
							end
						end else begin
							// Foreign address or bad opcode: stay quiet
							st_d = dpw_pkg::ST_WAIT;
						end
					end
				end
				dpw_pkg::ST_RDATA: begin
					if (scl_rise && cnt_q != `DPW_BITS_PER_BYTE) begin
						tx_d  = {tx_q[6:0], 1'b0};
						cnt_d = cnt_q + `DPW_CNT_STEP;
					end else if (scl_fall &&
						cnt_q == `DPW_BITS_PER_BYTE) begin
						oe_d = 1'b0;
					end else if (scl_fall) begin
						oe_d = ~tx_q[7];
					end else if (scl_rise) begin
						if (!sda_s) begin
							// Acknowledged: send the register again
							tx_d  = wip_q[sel_q];
							cnt_d = `DPW_CNT_ZERO;
						end else begin
							st_d = dpw_pkg::ST_WAIT;
						end
					end
				end
				dpw_pkg::ST_STEP: begin
					// pin never driven in step mode
					if (scl_rise) begin
						if (sda_s && wip_q[sel_q] != `DPW_WIPER_MAX) begin
							wip_d[sel_q] = wip_q[sel_q] + `DPW_WIPER_STEP;
						end else if (!sda_s &&
							wip_q[sel_q] != `DPW_WIPER_MIN) begin
							wip_d[sel_q] = wip_q[sel_q] - `DPW_WIPER_STEP;
						end
					end
				end
				dpw_pkg::ST_IDLE, dpw_pkg::ST_WAIT: begin
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// Command engine registers
	always_ff @(posedge lclk_i) begin
		if (lrst_s) begin
			st_q     <= dpw_pkg::ST_IDLE;
			nxt_q    <= dpw_pkg::ST_IDLE;
			cnt_q    <= `DPW_CNT_ZERO;
			shr_q    <= 8'h00;
			tx_q     <= 8'h00;
			oe_q     <= 1'b0;
			ack_q    <= 1'b0;
			sel_q    <= 1'b0;
			wip_q[0] <= `DPW_WIPER_RESET;
			wip_q[1] <= `DPW_WIPER_RESET;
		end else if (lce_s) begin
			st_q     <= st_d;
			nxt_q    <= nxt_d;
			cnt_q    <= cnt_d;
			shr_q    <= shr_d;
			tx_q     <= tx_d;
			oe_q     <= oe_d;
			ack_q    <= ack_d;
			sel_q    <= sel_d;
			wip_q    <= wip_d;
		end
	end

	// Publish both wipers whenever the last word was taken
	always_comb begin
		hold_d = hold_q;
		req_d  = req_q;
		if (req_q == back_s) begin
			hold_d.zero = wip_q[0];
			hold_d.one  = wip_q[1];
			req_d       = ~req_q;
		end
	end

	// Link side handshake registers; hold stays put while req is open
	always_ff @(posedge lclk_i) begin
		if (lrst_s) begin
			hold_q <= {`DPW_WIPER_RESET, `DPW_WIPER_RESET};
			req_q  <= 1'b0;
			back_m <= 1'b0;
			back_s <= 1'b0;
		end else if (lce_s) begin
			hold_q <= hold_d;
			req_q  <= req_d;
			back_m <= back_q;
			back_s <= back_m;
		end
	end

	// Take a new word when the request toggle arrives
	always_comb begin
		wiper_d = wiper_o;
		back_d  = back_q;
		if (req_s != back_q) begin
			wiper_d = hold_q;
			back_d  = req_s;
		end
	end

	// System side handshake and wiper copy
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			req_m   <= 1'b0;
			req_s   <= 1'b0;
			back_q  <= 1'b0;
			wiper_o <= {`DPW_WIPER_RESET, `DPW_WIPER_RESET};
		end else if (ce_i) begin
			req_m   <= req_q;
			req_s   <= req_m;
			back_q  <= back_d;
			wiper_o <= wiper_d;
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_pot
		dpw_tap_decode #(
			.WIDTH (WIDTH),
			.TAPS  (TAPS)
		) u_dec (
			.mclk_i (mclk_i),
			.rst_i  (rst_i),
			.ce_i   (ce_i),
			.pos_i  ((p == 0) ? wiper_o.zero : wiper_o.one),
			.taps_o (tap_o[p])
		);
	end

endmodule : dpw_slave

// >>> verilog/dpw_tap_decode.sv
// One-hot tap selection decoder for one wiper
`timescale 1ns/10ps
`include "dpw_cfg.svh"

module dpw_tap_decode #(
	parameter int WIDTH = 8,
	parameter int TAPS  = 256
) (
	// Clock, reset, enable
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	// Wiper position in
	input  wire logic [WIDTH-1:0] pos_i,
	// One-hot tap switches out
	output logic      [TAPS-1:0]  taps_o
);

	localparam logic [TAPS-1:0] RST_TAPS =
		{{(TAPS-1){1'b0}}, 1'b1} << `DPW_WIPER_RESET;

	logic [TAPS-1:0] taps_d;

	// One compare per tap switch
	for (genvar i = 0; i < TAPS; i++) begin : g_tap
		assign taps_d[i] = (pos_i == WIDTH'(i));
	end

	// Registered so the switches never see decode glitches
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			taps_o <= RST_TAPS;
		end else if (ce_i) begin
			taps_o <= taps_d;
		end
	end

endmodule : dpw_tap_decode
